// [sacs_host_model.sv]
// host side of the serial link: select, address, shift clock and
// a free-running conversion clock, all changed at the fall of mclk
// assumes mclk is the bench clock; trk mirrors the sampling level
module sacs_host_model
   import sacs_pkg::*;
(
   input wire logic mclk,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic trk,
   output sacs_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   int sys_div = 0; // conversion clock divider
   bit shared = 1'b0; // one clock drives both clock pins
   initial pins = 4'b1000; // deselected, clocks low
   // 120 ns conversion clock, no phase tie to io_clk
   always @(negedge mclk) begin
      sys_div = (sys_div + 1) % 3;
      if (sys_div == 0 && !shared) pins.sys_clk <= ~pins.sys_clk;
   end
   // shared-clock access: two recognition clocks carry a wrong
   // address bit, then ten shift cycles
   task automatic xfer_sh(input logic [3:0] a, output logic [9:0] got,
                          output logic [1:0] smp);
      @(negedge mclk);
      shared = 1'b1; // free-running clock stops from here
      @(negedge mclk);
      pins.sys_clk = 1'b0;
      repeat (4) @(negedge mclk);
      pins.cs_n = 1'b0;
      for (int k = 1; k <= 12; k++) begin
         if (k <= 2) pins.addr = ~a[3];
         else if (k <= 6) pins.addr = a[6-k]; // msb first
         repeat (4) @(negedge mclk);
         pins.io_clk = 1'b1;
         pins.sys_clk = 1'b1;
         repeat (4) @(negedge mclk);
         if (k >= 3) got[12-k] = dout; // bit before valid fall k-2
         if (k == 7) smp[0] = trk;
         if (k == 12) smp[1] = trk;
         pins.io_clk = 1'b0;
         pins.sys_clk = 1'b0;
      end
      @(negedge mclk);
      pins.cs_n = 1'b1; // raised after the twelfth clock
   endtask
   // common clock cycles; with select high they pace the conversion
   task automatic run_clk(input int n);
      repeat (n) begin
         repeat (4) @(negedge mclk);
         pins.io_clk = 1'b1;
         pins.sys_clk = 1'b1;
         repeat (4) @(negedge mclk);
         pins.io_clk = 1'b0;
         pins.sys_clk = 1'b0;
      end
   endtask
   // one access: select if needed, ten shift cycles of 160 ns
   task automatic xfer(input logic [3:0] a, output logic [9:0] got,
                       output logic [1:0] smp, output bit ok);
      int n;
      ok = 1'b1;
      @(negedge mclk);
      if (pins.cs_n) begin
         pins.cs_n = 1'b0; // select fall also aborts
         n = 0;
         // bounded wait for the output to come out of float
         while (dout_oe_n !== 1'b0 && n < 40) begin
            @(negedge mclk);
            n++;
         end
         ok = (n < 40);
      end
      for (int k = 1; k <= 10; k++) begin
         if (k <= 4) pins.addr = a[4-k]; // msb first
         else pins.addr = ~pins.addr; // don't-care bits keep moving
         repeat (4) @(negedge mclk);
         pins.io_clk = 1'b1; // long high on 10th is legal
         repeat (4) @(negedge mclk);
         got[10-k] = dout; // bit standing just before fall k
         if (k == 5) smp[0] = trk;
         if (k == 10) smp[1] = trk;
         pins.io_clk = 1'b0; // stays low until next access
      end
   endtask
   // deselect; held high until conversion ends unless testing abort
   task automatic release_cs;
      @(negedge mclk);
      pins.cs_n = 1'b1;
   endtask
   // shift clock and address toggling while deselected
   task automatic wiggle(input int n);
      repeat (n) begin
         repeat (4) @(negedge mclk);
         pins.io_clk = ~pins.io_clk;
         pins.addr = ~pins.addr;
      end
   endtask
endmodule // sacs_host_model

// [sacs_pkg.sv]
// types shared by the sequencer and its surroundings
// assumes sacs_regs.svh is on the include path
package sacs_pkg;
   // raw link pins, all asynchronous to mclk
   typedef struct packed {
      logic cs_n;     // chip select, active low
      logic addr;     // serial channel address
      logic io_clk;   // shift clock
      logic sys_clk;  // conversion clock
   } sacs_pins_t;
   // controls toward the analog front end
   typedef struct packed {
      logic sample;          // track the selected input
      logic convert;         // hold and convert
      logic [3:0] chan;      // selected channel
      logic self_test_channel; // internal test voltage picked
   } sacs_ana_t;
   // link state, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM  = 3'b010,
      ST_ACT  = 3'b100
   } sacs_state_t;
endpackage

// [sacs_regs.svh]
// constants of the serial converter control sequencer
// assumes one 50 mhz clock (mclk) samples every pin of the link
// Summary of operation
// RULE_01 - chip select high: output floats, inputs ignored
// RULE_02 - low select valid after two rises, one fall
// RULE_03 - recognised select shows old result msb
// RULE_04 - four address bits in, msb first
// RULE_05 - first four falls shift result bits two-five
// RULE_06 - sampling starts after fourth falling edge
// RULE_07 - next five falls shift bits six-ten
// RULE_08 - tenth fall holds; convert 44 system clocks
// RULE_09 - host waits 44 clocks or raises select
// RULE_10 - select may stay low over conversions
// RULE_11 - valid select fall aborts running conversion
// RULE_12 - new access aborts; previous result stays
// RULE_13 - system and shift clocks fully independent
// RULE_14 - shared clock: two recognition clocks skip address
// RULE_15 - shared clock converts once select high
// RULE_16 - shared clock: host raises select after twelve
// RULE_17 - sampling lasts until tenth falling edge
// RULE_18 - address 1011 picks internal self-test voltage
// RULE_19 - finished conversion loads result, shifted msb first
`ifndef SACS_REGS_SVH
`define SACS_REGS_SVH
`define SACS_RES_BITS 10
`define SACS_ADDR_BITS 4
`define SACS_CONV_CYCLES 6'd44
`define SACS_CONV_LAST 6'd43
`define SACS_RECOG_RISES 2'd2
`define SACS_SAMPLE_EDGE 4'd3
`define SACS_LAST_EDGE 4'd9
`define SACS_ADDR_EDGES 4'd4
`define SACS_SELF_TEST_CHAN 4'hb
`define SACS_RESULT_RST 10'h000
`define SACS_PINS_RST 4'h8
`endif

// [sacs_seq.sv]
// sequencer: chip select recognition, address/result shifting,
// sample/hold timing and the 44-cycle conversion count
// assumes all pins are asynchronous to mclk; conv_data is the
// comparator result from the front end, valid at conversion end
`include "sacs_regs.svh"
module sacs_seq
   import sacs_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire sacs_pins_t pins,
   input wire logic [9:0] conv_data,
   output logic dout,
   output logic dout_oe_n,
   output sacs_ana_t ana
);
   // rising edge of a sampled level
   function automatic logic rise(input logic cur, input logic prev);
      rise = cur & ~prev;
   endfunction
   // falling edge of a sampled level
   function automatic logic fall(input logic cur, input logic prev);
      fall = ~cur & prev;
   endfunction
   // result bit picked by the count of shift falls seen
   function automatic logic pick(input logic [9:0] r,
                                 input logic [3:0] n);
      pick = r[4'd9 - n];
   endfunction

   sacs_pins_t s1_q; // first sync stage, read only by s2
   sacs_pins_t s2_q; // synchronised pins
   sacs_pins_t s3_q; // previous synchronised value, for edges

   // two-flop synchronisers, plus one stage for edge finding
   // both clocks are only sampled, so no phase relation is needed
   // reset to the idle pin levels, so no false edge follows reset
   always_ff @(posedge mclk) begin // [RULE_13]
      if (reset) begin
         s1_q <= `SACS_PINS_RST;
         s2_q <= `SACS_PINS_RST;
         s3_q <= `SACS_PINS_RST;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic sys_r, sys_f, io_r, io_f;
   assign sys_r = rise(s2_q.sys_clk, s3_q.sys_clk);
   assign sys_f = fall(s2_q.sys_clk, s3_q.sys_clk);
   assign io_r = rise(s2_q.io_clk, s3_q.io_clk);
   assign io_f = fall(s2_q.io_clk, s3_q.io_clk);

   sacs_state_t state_q, state_d; // link state
   logic [1:0] rises_q, rises_d;  // system rises seen while arming
   logic [3:0] cnt_q, cnt_d;      // shift falls in this access
   logic [3:0] addr_q, addr_d;    // address shifter
   logic [9:0] result_q, result_d; // output register
   logic dout_q, dout_d;          // serial output bit
   logic sample_q, sample_d;      // sampling active
   logic [3:0] chan_q, chan_d;    // channel being sampled
   logic busy_q, busy_d;          // conversion running
   logic [5:0] conv_q, conv_d;    // system clocks of conversion
   logic recog;                   // select just recognised
   logic last_fall;               // tenth shift fall

   // both need select still low, or a raised select would skip a
   // conversion clock without starting or aborting anything
   assign recog = (state_q == ST_ARM) && !s2_q.cs_n && sys_f &&
                  (rises_q == `SACS_RECOG_RISES);
   assign last_fall = (state_q == ST_ACT) && !s2_q.cs_n && io_f &&
                      (cnt_q == `SACS_LAST_EDGE);

   // next-state and datapath computation
   always_comb begin
      state_d = state_q;
      rises_d = rises_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      result_d = result_q;
      dout_d = dout_q;
      sample_d = sample_q;
      chan_d = chan_q;
      busy_d = busy_q;
      conv_d = conv_q;
      unique case (state_q)
         ST_IDLE: begin
            // select high: shift clock and address ignored
            if (!s2_q.cs_n) begin // [RULE_01]
               state_d = ST_ARM;
               rises_d = 2'd0;
            end
         end
         ST_ARM: begin
            // shared clock: these edges never shift address
            if (s2_q.cs_n) begin // [RULE_14]
               state_d = ST_IDLE;
            end else if (recog) begin // [RULE_02]
               state_d = ST_ACT;
               cnt_d = 4'd0;
               // a valid select fall resets a running conversion
               busy_d = 1'b0; // [RULE_11]
               sample_d = 1'b0;
            end else if (sys_r && rises_q != `SACS_RECOG_RISES) begin
               rises_d = rises_q + 2'd1;
            end
         end
         ST_ACT: begin
            if (s2_q.cs_n) begin
               state_d = ST_IDLE;
               sample_d = 1'b0;
            end else begin
               // address in on the first four rises, msb first
               if (io_r && cnt_q < `SACS_ADDR_EDGES) begin // [RULE_04]
                  addr_d = {addr_q[2:0], s2_q.addr};
               end
               if (io_f) begin
                  // select may stay low: wrap for the next access
                  cnt_d = (cnt_q == `SACS_LAST_EDGE) ? 4'd0 :
                          cnt_q + 4'd1; // [RULE_10]
                  if (cnt_q == `SACS_SAMPLE_EDGE) begin // [RULE_06]
                     sample_d = 1'b1;
                     chan_d = addr_q;
                  end
                  if (last_fall) begin // [RULE_08] [RULE_17]
                     sample_d = 1'b0;
                     // restart drops the old one, result untouched
                     busy_d = 1'b1; // [RULE_12]
                     conv_d = 6'd0;
                  end
               end
            end
         end
      endcase
      // conversion paced by the system clock; in shared-clock use
      // that is the common clock, so it runs once select is high
      if (busy_q && !last_fall && !recog && sys_r) begin // [RULE_15]
         if (conv_q == `SACS_CONV_LAST) begin // [RULE_08]
            busy_d = 1'b0;
            result_d = conv_data; // [RULE_19]
         end else begin
            conv_d = conv_q + 6'd1;
         end
      end
      // output bit follows the shift count; msb right at recognition
      if (state_d == ST_ACT) begin // [RULE_03] [RULE_05] [RULE_07]
         dout_d = pick(result_d, cnt_d);
      end
   end

   // register stage
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= ST_IDLE;
         rises_q <= 2'd0;
         cnt_q <= 4'd0;
         addr_q <= 4'd0;
         result_q <= `SACS_RESULT_RST;
         dout_q <= 1'b0;
         sample_q <= 1'b0;
         chan_q <= 4'd0;
         busy_q <= 1'b0;
         conv_q <= 6'd0;
      end else begin
         state_q <= state_d;
         rises_q <= rises_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         result_q <= result_d;
         dout_q <= dout_d;
         sample_q <= sample_d;
         chan_q <= chan_d;
         busy_q <= busy_d;
         conv_q <= conv_d;
      end
   end

   // output floats except while select is recognised low
   assign dout_oe_n = (state_q != ST_ACT); // [RULE_01]
   assign dout = dout_q;
   assign ana.sample = sample_q;
   assign ana.convert = busy_q;
   assign ana.chan = chan_q;
   // test voltage chosen by the reserved address
   assign ana.self_test_channel =
      (chan_q == `SACS_SELF_TEST_CHAN); // [RULE_18]

   // checks
   sequence s_io_fall_at(logic [3:0] n);
      (state_q == ST_ACT) && !s2_q.cs_n && io_f && (cnt_q == n);
   endsequence
   sequence s_conv_end;
      busy_q && sys_r && (conv_q == `SACS_CONV_LAST) &&
      !last_fall && !recog;
   endsequence

   property p_float_idle;
      @(posedge mclk) disable iff (reset)
      (state_q != ST_ACT) |-> dout_oe_n;
   endproperty
   a_float_idle: assert property (p_float_idle) // [RULE_01]
      else $error("output driven while select not valid");

   property p_recog;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_ARM) && !s2_q.cs_n && sys_f &&
      (rises_q == 2'd2) |=> (state_q == ST_ACT) && !dout_oe_n;
   endproperty
   a_recog: assert property (p_recog) // [RULE_02]
      else $error("select not recognised after rises and fall");

   property p_msb;
      @(posedge mclk) disable iff (reset)
      $rose(state_q == ST_ACT) |-> dout_q == result_q[9];
   endproperty
   a_msb: assert property (p_msb) // [RULE_03]
      else $error("msb not shown at recognition");

   property p_addr;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_ACT) && !s2_q.cs_n && io_r && cnt_q < 4'd4
      |=> addr_q == {$past(addr_q[2:0]), $past(s2_q.addr)};
   endproperty
   a_addr: assert property (p_addr) // [RULE_04]
      else $error("address bit not captured");

   property p_shift;
      @(posedge mclk) disable iff (reset)
      (state_q == ST_ACT) && !s2_q.cs_n && io_f && cnt_q < 4'd9
      && !(busy_q && sys_r && conv_q == 6'd43)
      |=> dout_q == result_q[4'd8 - $past(cnt_q)];
   endproperty
   a_shift: assert property (p_shift) // [RULE_05] [RULE_07]
      else $error("wrong result bit shifted");

   property p_sample;
      @(posedge mclk) disable iff (reset)
      s_io_fall_at(4'd3) |=> sample_q ##0 sample_q[*1];
   endproperty
   a_sample: assert property (p_sample) // [RULE_06]
      else $error("sampling did not start");

   property p_hold;
      @(posedge mclk) disable iff (reset)
      s_io_fall_at(4'd9) |=> !sample_q && busy_q && conv_q == 6'd0;
   endproperty
   a_hold: assert property (p_hold) // [RULE_08]
      else $error("hold or conversion start missing");

   property p_load;
      @(posedge mclk) disable iff (reset)
      s_conv_end |=> !busy_q && result_q == $past(conv_data);
   endproperty
   a_load: assert property (p_load) // [RULE_19]
      else $error("result not loaded at conversion end");

   property p_abort;
      @(posedge mclk) disable iff (reset)
      recog |=> !busy_q;
   endproperty
   a_abort: assert property (p_abort) // [RULE_11]
      else $error("conversion survived select recognition");

   property p_keep;
      @(posedge mclk) disable iff (reset)
      !(busy_q && sys_r && (conv_q == `SACS_CONV_LAST) && !last_fall &&
        !recog) |=> $stable(result_q);
   endproperty
   a_keep: assert property (p_keep) // [RULE_12]
      else $error("result changed without a finished conversion");

   property p_test_chan;
      @(posedge mclk) disable iff (reset)
      ana.self_test_channel == (chan_q == 4'hb);
   endproperty
   a_test_chan: assert property (p_test_chan) // [RULE_18]
      else $error("self-test channel not selected");
endmodule // sacs_seq

// [tb.sv]
// self-checking bench for the serial converter sequencer
// assumes the host model drives every link pin; conv_data random
module tb;
   import sacs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin \
   err_total++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); \
   end end
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [9:0] conv_data = 10'h000;
   logic dout;
   logic dout_oe_n;
   sacs_pins_t pins;
   sacs_ana_t ana;
   int err_total = 0;
   int cmp_count = 0;
   int seed = 2591;
   int exp_res = 0; // model: last result that finished converting
   logic [9:0] got;
   logic [1:0] smp;
   bit ok;
   logic [9:0] sh_cv; // result of the shared-clock conversion
   always #10 mclk = ~mclk; // 50 mhz
   sacs_seq i_dut (.mclk(mclk), .reset(reset), .pins(pins),
      .conv_data(conv_data), .dout(dout), .dout_oe_n(dout_oe_n),
      .ana(ana));
   sacs_host_model i_host (.mclk(mclk), .dout(dout),
      .dout_oe_n(dout_oe_n), .trk(ana.sample), .pins(pins));
   task automatic end_sim;
      $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one access; keep leaves select low, done lets conversion end
   task automatic acc(input logic [3:0] a, input bit keep,
                      input bit done);
      logic [9:0] cv;
      cv = 10'($random(seed));
      conv_data = cv;
      i_host.xfer(a, got, smp, ok);
      `CHK(ok, 1'b1)
      `CHK(got, 10'(exp_res))
      `CHK(smp, 2'b11)
      repeat (8) @(negedge mclk);
      `CHK({ana.sample, ana.convert, ana.chan}, {2'b01, a})
      `CHK(ana.self_test_channel, a == 4'hb)
      if (!keep) begin
         i_host.release_cs();
         repeat (10) @(negedge mclk);
         `CHK(dout_oe_n, 1'b1)
      end
      if (done) begin
         // 44 conversion clocks of 6 mclk each, plus sync slack
         repeat (230) @(negedge mclk);
         `CHK(ana.convert, 1'b1)
         repeat (60) @(negedge mclk);
         `CHK(ana.convert, 1'b0)
         exp_res = cv;
      end
      $display("access %h finished", a);
   endtask
   // watchdog: whole run is about 2700 cycles
   initial begin
      #400us;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (10) @(negedge mclk);
      reset = 1'b0;
      `CHK({dout_oe_n, ana}, 8'h80)
      i_host.wiggle(6); // deselected traffic is ignored
      `CHK({dout_oe_n, ana.sample}, 2'b10)
      $display("idle test finished");
      acc(4'hb, 1'b0, 1'b1);
      acc(4'h5, 1'b0, 1'b1);
      acc(4'($random(seed)), 1'b1, 1'b1); // select held low
      acc(4'h0, 1'b1, 1'b0); // aborted by the next access
      acc(4'ha, 1'b0, 1'b0); // select raised too early
      acc(4'h3, 1'b0, 1'b1); // its select fall aborts the last one
      // shared clock: first two clocks only recognise select
      sh_cv = 10'($random(seed));
      conv_data = sh_cv;
      i_host.xfer_sh(4'h6, got, smp);
      `CHK(got, 10'(exp_res))
      `CHK(smp, 2'b11)
      repeat (8) @(negedge mclk);
      `CHK({dout_oe_n, ana}, 8'hac)
      i_host.run_clk(43);
      `CHK(ana.convert, 1'b1)
      i_host.run_clk(1);
      repeat (4) @(negedge mclk);
      `CHK(ana.convert, 1'b0)
      exp_res = sh_cv;
      i_host.shared = 1'b0;
      $display("shared clock access finished");
      acc(4'h7, 1'b0, 1'b1);
      end_sim();
   end
endmodule // tb
